// file: hw/mts_sequencer.sv
// Notes on behaviour
// - write every memory location first, then read every location back
// - compare readback against a regenerated pattern, never a stored copy
// - the start button produces the controls that launch a test run
// - indicator 0 shows reset, 1 shows pass, 2 blinks in every state but hold
// - all three indicators are on while the start button is held
// - on button release pass and heartbeat indicators blink during the run
// - on full pass the pass indicator stops blinking and stays lit
// - heartbeat blinking comes from i_clk_sys, the 25 MHz system clock, not the 50 MHz reference; no clock, no blink
// - pass indicator blinks only after init done and calibration success
// - a mismatch leaves the pass indicator blinking, never steady
// - another button press after a run starts a completely new run
// - controller runs off 50 MHz reference, 400 MHz memory, 200 MHz core
`timescale 1ns/1ns
`default_nettype none
module mts_sequencer #(
  parameter int ADDR_W = mts_pkg::ADDR_W,
  parameter int BLINK_HALF = mts_pkg::BLINK_HALF_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_start_button_n,
  input wire logic i_init_done,
  input wire logic i_cal_success,
  output logic [ADDR_W-1:0] o_address,
  output logic o_write,
  output logic o_read,
  output logic [mts_pkg::DATA_W-1:0] o_writedata,
  input wire logic i_waitrequest,
  input wire logic [mts_pkg::DATA_W-1:0] i_readdata,
  input wire logic i_readdatavalid,
  output logic [2:0] o_status_indicators,
  output logic o_test_done,
  output logic o_test_fail
);
  import mts_pkg::*;

  mts_state_t state_q;
  mts_state_t state_d;

  logic btn_meta_q;
  logic btn_sync_q;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic [ADDR_W-1:0] chk_q;
  logic [ADDR_W-1:0] chk_d;
  logic rd_all_q;
  logic rd_all_d;
  logic [2:0] led_q;
  logic [2:0] led_d;
  logic blink;
  logic [DATA_W-1:0] wr_word;
  logic [DATA_W-1:0] chk_word;

  // button is active low on the pin; two flops before any use
  wire btn_held = btn_sync_q;
  wire mem_ready = i_init_done & i_cal_success;
  wire in_write = (state_q == MTS_ST_WRITE);
  wire in_read = (state_q == MTS_ST_READ);
  wire wr_take = in_write & ~i_waitrequest;
  // stop issuing once every address is out; answers may still lag
  wire rd_issue = in_read & ~rd_all_q;
  wire rd_take = rd_issue & ~i_waitrequest;
  wire rd_back = in_read & i_readdatavalid;
  wire addr_last = (addr_q == {ADDR_W{1'b1}});
  wire chk_last = (chk_q == {ADDR_W{1'b1}});
  // only the replayed copy is compared; nothing kept from the writes
  wire chk_match = (i_readdata == chk_word);
  // restart pulse covers the whole button hold, so release starts clean
  wire restart = btn_held;

  mts_pattern_gen u_wr_gen (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_restart(restart),
    .i_advance(wr_take),
    .o_word(wr_word)
  );

  // second generator replays the write sequence for checking
  mts_pattern_gen u_chk_gen (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_restart(restart),
    .i_advance(rd_back),
    .o_word(chk_word)
  );

  // free-running from the i_clk_sys domain (25 MHz), not the 50 MHz reference clock of the board
  mts_blink #(
    .HALF_CYC(BLINK_HALF)
  ) u_blink (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .o_level(blink)
  );

  // controller derives its own clocks; the host port is seen on this clock
  // and waitrequest stretches every transfer to the controller's pace
  assign o_address = addr_q;
  assign o_writedata = wr_word;
  assign o_write = in_write;
  assign o_read = rd_issue;
  assign o_status_indicators = led_q;
  assign o_test_done = (state_q == MTS_ST_PASS) | (state_q == MTS_ST_FAIL);
  assign o_test_fail = (state_q == MTS_ST_FAIL);

  // a held button overrides every state, so a press aborts any run
  always_comb
  begin
    state_d = state_q;
    if (btn_held)
    begin
      state_d = MTS_ST_HOLD;
    end
    else
    begin
      unique case (state_q)
        MTS_ST_HOLD:
        begin
          state_d = MTS_ST_WAIT_CAL;
        end
        MTS_ST_WAIT_CAL:
        begin
          if (mem_ready)
          begin
            state_d = MTS_ST_WRITE;
          end
        end
        MTS_ST_WRITE:
        begin
          if (wr_take && addr_last)
          begin
            state_d = MTS_ST_READ;
          end
        end
        MTS_ST_READ:
        begin
          // a bad word wins over the last word, so a fail never reads as pass
          if (rd_back && !chk_match)
          begin
            state_d = MTS_ST_FAIL;
          end
          else if (rd_back && chk_last)
          begin
            state_d = MTS_ST_PASS;
          end
        end
        // results hold until the next press
        MTS_ST_PASS:
        begin
          state_d = MTS_ST_PASS;
        end
        MTS_ST_FAIL:
        begin
          state_d = MTS_ST_FAIL;
        end
        default:
        begin
          state_d = MTS_ST_HOLD;
        end
      endcase
    end
  end

  // one address counter serves both passes; it wraps to zero after writing
  always_comb
  begin
    addr_d = addr_q;
    rd_all_d = rd_all_q;
    chk_d = chk_q;
    if (restart)
    begin
      addr_d = '0;
      rd_all_d = 1'b0;
      chk_d = '0;
    end
    else
    begin
      if (wr_take || rd_take)
      begin
        addr_d = addr_q + ADDR_W'(1);
      end
      if (rd_take && addr_last)
      begin
        rd_all_d = 1'b1;
      end
      if (rd_back)
      begin
        chk_d = chk_q + ADDR_W'(1);
      end
    end
  end

  // hold forces all on; elsewhere the heartbeat never stops
  always_comb
  begin
    led_d = LED_ALL_OFF;
    led_d[LED_BEAT] = blink;
    unique case (state_q)
      MTS_ST_HOLD:
      begin
        led_d = LED_ALL_ON;
      end
      MTS_ST_WAIT_CAL:
      begin
        led_d[LED_PASS] = 1'b0;
      end
      MTS_ST_WRITE, MTS_ST_READ:
      begin
        led_d[LED_PASS] = blink;
      end
      MTS_ST_PASS:
      begin
        led_d[LED_PASS] = 1'b1;
      end
      MTS_ST_FAIL:
      begin
        led_d[LED_PASS] = blink;
      end
      default:
      begin
        led_d = LED_ALL_ON;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      btn_meta_q <= 1'b0;
      btn_sync_q <= 1'b0;
    end
    else
    begin
      btn_meta_q <= ~i_start_button_n;
      btn_sync_q <= btn_meta_q;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_q <= MTS_ST_HOLD;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // cleared only by reset; a press restarts it through addr_d
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      addr_q <= '0;
    end
    else
    begin
      addr_q <= addr_d;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rd_all_q <= 1'b0;
    end
    else
    begin
      rd_all_q <= rd_all_d;
    end
  end

  // counts answers, which lag the issued reads
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      chk_q <= '0;
    end
    else
    begin
      chk_q <= chk_d;
    end
  end

  // registered so the pins never see decode glitches
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      led_q <= LED_ALL_ON;
    end
    else
    begin
      led_q <= led_d;
    end
  end
endmodule : mts_sequencer
`default_nettype wire

// file: shared/mts_pkg.sv
package mts_pkg;
  // pattern word and memory geometry
  localparam int DATA_W = 32;
  localparam int ADDR_W = 28;
  localparam logic [31:0] PATTERN_SEED = 32'h1357_9bdf;
  localparam logic [31:0] PATTERN_TAPS = 32'h8020_0003;
  // timing
  localparam int CLK_HZ = 25_000_000;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_HALF_MS;
  // controller clocking as seen by the host port
  localparam int REF_CLK_MHZ = 50;
  localparam int MEM_CLK_MHZ = 400;
  localparam int CTL_CLK_MHZ = 200;
  localparam int DATA_RATE_MBPS = 2 * MEM_CLK_MHZ;
  // indicator bit positions
  localparam int LED_RESET = 0;
  localparam int LED_PASS = 1;
  localparam int LED_BEAT = 2;
  localparam logic [2:0] LED_ALL_ON = 3'h7;
  localparam logic [2:0] LED_ALL_OFF = 3'h0;

  typedef enum logic [2:0] {
    MTS_ST_HOLD = 3'b000,
    MTS_ST_WAIT_CAL = 3'b001,
    MTS_ST_WRITE = 3'b010,
    MTS_ST_READ = 3'b011,
    MTS_ST_PASS = 3'b100,
    MTS_ST_FAIL = 3'b101
  } mts_state_t;
endpackage : mts_pkg

// file: hw/mts_pattern_gen.sv
`timescale 1ns/1ns
`default_nettype none
module mts_pattern_gen
  import mts_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_restart,
  input wire logic i_advance,
  output logic [mts_pkg::DATA_W-1:0] o_word
);
  logic [DATA_W-1:0] lfsr_q;
  logic [DATA_W-1:0] lfsr_d;
  wire feedback = lfsr_q[0];
  wire [DATA_W-1:0] shifted = {1'b0, lfsr_q[DATA_W-1:1]};
  wire [DATA_W-1:0] stepped = feedback ? (shifted ^ PATTERN_TAPS) : shifted;

  // restart wins so both copies start from the same seed
  assign lfsr_d = i_restart ? PATTERN_SEED : (i_advance ? stepped : lfsr_q);
  assign o_word = lfsr_q;

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      lfsr_q <= PATTERN_SEED;
    end
    else
    begin
      lfsr_q <= lfsr_d;
    end
  end
endmodule : mts_pattern_gen
`default_nettype wire

// file: hw/mts_blink.sv
`timescale 1ns/1ns
`default_nettype none
module mts_blink #(
  parameter int HALF_CYC = mts_pkg::BLINK_HALF_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  output logic o_level
);
  localparam int CNT_W = $clog2(HALF_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(HALF_CYC - 1);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic level_q;
  wire wrap = (cnt_q == CNT_LAST);

  assign cnt_d = wrap ? '0 : cnt_q + CNT_W'(1);
  assign o_level = level_q;

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cnt_q <= '0;
      level_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      level_q <= wrap ? ~level_q : level_q;
    end
  end
endmodule : mts_blink
`default_nettype wire

// file: testbench/mts_sequencer_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module mts_seq_chk #(
  parameter int ADDR_W = 4,
  parameter int BLINK_HALF = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_start_button_n,
  input wire logic [ADDR_W-1:0] o_address,
  input wire logic o_write,
  input wire logic o_read,
  input wire logic [mts_pkg::DATA_W-1:0] o_writedata,
  input wire logic i_waitrequest,
  input wire logic [2:0] o_status_indicators,
  input wire logic o_test_done,
  input wire logic o_test_fail
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  logic beat_q;
  int run_q;
  // cycles the heartbeat sat still outside hold
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      beat_q <= 1'b1;
      run_q <= 0;
    end
    else
    begin
      beat_q <= o_status_indicators[2];
      run_q <= (o_status_indicators[0] || beat_q != o_status_indicators[2]) ? 0 : run_q + 1;
    end
  end
  sequence s_held;
    !i_start_button_n [*4];
  endsequence
  sequence s_wr_stall;
    o_write && i_waitrequest;
  endsequence
  a_one_request: assert property (!(o_write && o_read))
    else $error("both requests");
  a_write_holds: assert property (s_wr_stall |=> o_write && $stable(o_address)
    && $stable(o_writedata)) else $error("write dropped");
  a_read_holds: assert property (o_read && i_waitrequest |=> o_read
    && $stable(o_address)) else $error("read dropped");
  a_addr_steps: assert property ((o_write || o_read) && !i_waitrequest ##1 o_read
    |-> o_address == ADDR_W'($past(o_address) + 1'b1)) else $error("address skip");
  a_button_lights: assert property (s_held |=> o_status_indicators == 3'h7)
    else $error("leds not on");
  a_pass_lit: assert property (o_test_done && !o_test_fail [*2]
    |-> o_status_indicators[1]) else $error("pass led dark");
  a_done_quiet: assert property (o_test_done |-> !o_write && !o_read)
    else $error("request after done");
  a_reset_all: assert property (o_status_indicators[0]
    |-> o_status_indicators == 3'h7) else $error("reset led alone");
  a_beat_alive: assert property (run_q <= BLINK_HALF)
    else $error("heartbeat stuck");
endmodule : mts_seq_chk
bind mts_sequencer mts_seq_chk #(.ADDR_W(ADDR_W), .BLINK_HALF(BLINK_HALF)) u_chk (
  .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_start_button_n(i_start_button_n),
  .o_address(o_address), .o_write(o_write), .o_read(o_read), .o_writedata(o_writedata),
  .i_waitrequest(i_waitrequest), .o_status_indicators(o_status_indicators),
  .o_test_done(o_test_done), .o_test_fail(o_test_fail));
`default_nettype wire

// file: testbench/mts_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module mts_mem_model #(
  parameter int AW = 4
) (
  input wire logic i_clk,
  input wire logic [AW-1:0] i_address,
  input wire logic i_write,
  input wire logic i_read,
  input wire logic [31:0] i_writedata,
  input wire logic i_stall,
  input wire logic i_corrupt,
  output logic o_waitrequest,
  output logic [31:0] o_readdata,
  output var logic o_readdatavalid
);
  logic [31:0] mem_q [2**AW];
  assign o_waitrequest = i_stall;
  always @(posedge i_clk)
  begin
    o_readdatavalid <= i_read && !i_stall;
    // idle data inverted so a stale word never passes as fresh
    o_readdata <= (i_read && !i_stall) ? mem_q[i_address]
      ^ {31'h0000_0000, i_corrupt && i_address == AW'(5)} : ~o_readdata;
    if (i_write && !i_stall)
      mem_q[i_address] <= i_writedata;
  end
endmodule : mts_mem_model
`default_nettype wire

// file: testbench/mts_sequencer_test.sv
`timescale 1ns/1ns
`default_nettype none
module mts_sequencer_test;
  import mts_pkg::*;
  localparam int AW = 4;
  localparam int BH = 4;
  localparam int NW = 2**AW;
  logic clk, arst_n, btn_n, init, cal, stall, bad, wr, rd, wait_r, rv, done, fail;
  logic [AW-1:0] addr;
  logic [31:0] wdata, rdata;
  logic [2:0] leds;
  logic [31:0] rng = 32'h0000_004e;
  logic [31:0] pat = PATTERN_SEED;
  int num_errors = 0, checks_done = 0, cyc = 0, nw = 0, nr = 0;
  logic [31:0] wq[$], pq[$];
  mts_sequencer #(.ADDR_W(AW), .BLINK_HALF(BH)) u_mts_sequencer (.i_clk_sys(clk),
    .i_arst_n(arst_n), .i_start_button_n(btn_n), .i_init_done(init), .i_cal_success(cal),
    .o_address(addr), .o_write(wr), .o_read(rd), .o_writedata(wdata),
    .i_waitrequest(wait_r), .i_readdata(rdata), .i_readdatavalid(rv),
    .o_status_indicators(leds), .o_test_done(done), .o_test_fail(fail));
  mts_mem_model #(.AW(AW)) u_mts_mem_model (.i_clk(clk), .i_address(addr), .i_write(wr),
    .i_read(rd), .i_writedata(wdata), .i_stall(stall), .i_corrupt(bad),
    .o_waitrequest(wait_r), .o_readdata(rdata), .o_readdatavalid(rv));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim();
    if (num_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  // expected write pattern, stepped from the seed with the package taps
  function automatic logic [31:0] pat_next(input logic [31:0] x);
    return x[0] ? ((x >> 1) ^ PATTERN_TAPS) : (x >> 1);
  endfunction : pat_next
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic press();
    btn_n = 0;
    tick(10);
    chk(leds, 3'h7);
    chk(done, 0);
    nw = 0;
    nr = 0;
    wq = {};
    pat = PATTERN_SEED;
    btn_n = 1;
  endtask : press
  // run to completion, then watch the indicators for one blink period plus two cycles
  task automatic run(input logic f);
    int k, n1, n2;
    logic l1, l2;
    bad = f;
    k = 0;
    n1 = 0;
    n2 = 0;
    while (done !== 1'b1 && k < 3000)
    begin
      l1 = leds[1];
      tick(1);
      n1 += int'(leds[1] != l1);
      k++;
    end
    chk(n1 > 0, 1);
    chk(done, 1);
    chk(fail, f);
    // a failed run stops at most one read after the bad word at address 5
    chk(f ? (nr == 6 || nr == 7) : (nr == NW), 1);
    foreach (pq[i]) chk(wq[i], pq[i]);
    n1 = 0;
    tick(2);
    l1 = leds[1];
    l2 = leds[2];
    repeat (2 * BH + 2)
    begin
      tick(1);
      n1 += int'(leds[1] != l1);
      n2 += int'(leds[2] != l2);
      l1 = leds[1];
      l2 = leds[2];
    end
    chk(n1 > 0, f);
    chk(leds[1] | f, 1);
    chk(n2 > 0, 1);
  endtask : run
  initial
  begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (wr && !wait_r)
    begin
      chk(addr, nw);
      chk(wdata, pat);
      pat = pat_next(pat);
      wq.push_back(wdata);
      nw++;
    end
    if (rd && !wait_r)
    begin
      chk(nw, NW);
      chk(addr, nr);
      nr++;
    end
    #1;
    rng = xs(rng);
    stall = rng[0] & rng[1];
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      end_sim();
    end
  end
  initial
  begin
    arst_n = 0;
    btn_n = 1;
    init = 0;
    cal = 0;
    stall = 0;
    bad = 0;
    tick(16);
    chk(leds, 3'h7);
    arst_n = 1;
    init = 1;
    tick(10);
    chk(leds[1], 0);
    init = 0;
    cal = 1;
    tick(10);
    chk(leds[1], 0);
    chk(nw, 0);
    init = 1;
    run(0);
    chk(wq[0], PATTERN_SEED);
    pq = wq;
    press();
    run(1);
    press();
    run(0);
    end_sim();
  end
endmodule : mts_sequencer_test
`default_nettype wire
